/* hw/egress_port_sched.sv */
// Transmit queue selector for one egress port: strict or weighted service
`timescale 1ns/1ps
`default_nettype none

module egress_port_sched #(
  parameter int CREDIT_W = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Configuration
  input wire logic [3:0] sel_bits,
  input wire logic strict_global,
  input wire logic two_queue,
  // Queue side
  input wire logic [3:0] queue_pending,
  input wire logic frame_done,
  output logic [1:0] queue_sel_reg,
  output logic sel_valid_reg,
  output logic weighted_reg
);

  egress_sched_pkg::mode_t mode;
  logic [CREDIT_W-1:0] credit_reg [4];
  logic [CREDIT_W-1:0] credit_next [4];
  logic [CREDIT_W-1:0] weight [4];
  logic [CREDIT_W-1:0] base;
  logic [CREDIT_W-1:0] q3_credit;
  logic [3:0] lanes;
  logic [3:0] has_credit;
  logic [3:0] eligible;
  logic need_reload;
  logic [1:0] queue_sel_next;
  logic sel_valid_next;

  // Strict only when every select bit and the global bit are clear
  always_comb
  begin
    if (sel_bits == 4'h0 && !strict_global)
      mode = egress_sched_pkg::MODE_STRICT;
    else
      mode = egress_sched_pkg::MODE_WEIGHTED;
  end

  // Per-queue weight table for the current queue count
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      weight[i] = CREDIT_W'(egress_sched_pkg::weight_of(2'(i)));
    lanes = egress_sched_pkg::LANES_FOUR;
    if (two_queue)
    begin
      weight[3] = '0;
      weight[2] = '0;
      weight[1] = CREDIT_W'(egress_sched_pkg::WEIGHT2_HI);
      weight[0] = CREDIT_W'(egress_sched_pkg::WEIGHT2_LO);
      lanes = egress_sched_pkg::LANES_TWO;
    end
  end

  // Pick highest eligible queue; refill credits when all pending are spent
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      has_credit[i] = (credit_reg[i] != '0);
    eligible = queue_pending & lanes;
    need_reload = 1'b0;
    if (mode == egress_sched_pkg::MODE_WEIGHTED)
    begin
      need_reload = (eligible != 4'h0) && ((eligible & has_credit) == 4'h0);
      if (!need_reload)
        eligible = eligible & has_credit;
    end
    queue_sel_next = 2'h0;
    sel_valid_next = (eligible != 4'h0);
    for (int i = 0; i < 4; i++)
      if (eligible[i])
        queue_sel_next = 2'(i);
  end

  // Credit bookkeeping: spend one per finished frame
  always_comb
  begin
    base = '0;
    for (int i = 0; i < 4; i++)
      credit_next[i] = credit_reg[i];
    if (mode == egress_sched_pkg::MODE_STRICT)
    begin
      for (int i = 0; i < 4; i++)
        credit_next[i] = weight[i];
    end
    else if (frame_done && sel_valid_reg)
    begin
      if (need_reload)
        for (int i = 0; i < 4; i++)
          credit_next[i] = weight[i];
      base = credit_next[queue_sel_reg];
      if (base != '0)
        credit_next[queue_sel_reg] = base - CREDIT_W'(1);
    end
  end

  assign q3_credit = credit_reg[3];

  // Registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++)
        credit_reg[i] <= '0;
      queue_sel_reg <= 2'h0;
      sel_valid_reg <= 1'b0;
      weighted_reg <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        credit_reg[i] <= credit_next[i];
      queue_sel_reg <= queue_sel_next;
      sel_valid_reg <= sel_valid_next;
      weighted_reg <= (mode == egress_sched_pkg::MODE_WEIGHTED);
    end
  end

  property p_strict_top;
    @(posedge sys_clk) disable iff (!rst_n)
    (mode == egress_sched_pkg::MODE_STRICT && queue_pending[3] && !two_queue)
      |=> (sel_valid_reg && queue_sel_reg == 2'h3);
  endproperty
  a_strict_top: assert property (p_strict_top)
    else $error("strict mode did not pick queue 3");

  property p_two_lane;
    @(posedge sys_clk) disable iff (!rst_n)
    (two_queue && queue_pending[3:2] != 2'h0) |=> (!sel_valid_reg || queue_sel_reg <= 2'h1);
  endproperty
  a_two_lane: assert property (p_two_lane)
    else $error("two-queue port served queue 2 or 3");

  property p_credit_spend;
    @(posedge sys_clk) disable iff (!rst_n)
    (mode == egress_sched_pkg::MODE_WEIGHTED && !two_queue && frame_done && sel_valid_reg
      && queue_sel_reg == 2'h3 && queue_pending[3] && q3_credit > 4'h1)
      |=> (q3_credit == $past(q3_credit) - 4'h1);
  endproperty
  a_credit_spend: assert property (p_credit_spend)
    else $error("queue 3 credit not spent by one");

  property p_reload_eight;
    @(posedge sys_clk) disable iff (!rst_n)
    (mode == egress_sched_pkg::MODE_STRICT && !two_queue) |=> (q3_credit == 4'h8);
  endproperty
  a_reload_eight: assert property (p_reload_eight)
    else $error("queue 3 weight is not 8");

endmodule
`default_nettype wire

/* hw/egress_queue_sched_select.sv */
// Egress queue scheduling register bank for ports 2 and 3
//
// How it works
// - All selects clear, global bit clear: strict
// - All selects set, four queues: 8:4:2:1
// - All selects set, two queues: 2:1
// - Select is bit 7, read/write, resets 1
// - Low seven bits read fixed weights
// - Port 3 queue 0 select at 0xba
`timescale 1ns/1ps
`default_nettype none

module egress_queue_sched_select #(
  parameter int CREDIT_W = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Management register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // Global scheduling controls
  input wire logic strict_global,
  input wire logic p2_two_queue,
  input wire logic p3_two_queue,
  // Port 2 queue side
  input wire logic [3:0] p2_queue_pending,
  input wire logic p2_frame_done,
  output logic [1:0] p2_queue_sel,
  output logic p2_sel_valid,
  output logic p2_weighted,
  // Port 3 queue side
  input wire logic [3:0] p3_queue_pending,
  input wire logic p3_frame_done,
  output logic [1:0] p3_queue_sel,
  output logic p3_sel_valid,
  output logic p3_weighted
);

  localparam int IDX_W = 3;

  logic [egress_sched_pkg::NUM_SCHED_REGS-1:0] sel_reg;
  logic [egress_sched_pkg::NUM_SCHED_REGS-1:0] sel_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic addr_hit;
  logic [IDX_W-1:0] addr_idx;
  logic [7:0] addr_off;
  logic wdata_sel;
  logic [3:0] p2_sel_bits;
  logic [3:0] p3_sel_bits;

  // Decode the offset into one of the eight queue registers
  always_comb
  begin
    addr_off = reg_addr - egress_sched_pkg::OFS_FIRST;
    addr_hit = (reg_addr >= egress_sched_pkg::OFS_FIRST)
      && (reg_addr <= egress_sched_pkg::OFS_LAST);
    addr_idx = addr_off[IDX_W-1:0];
  end

  assign wdata_sel = reg_wdata[egress_sched_pkg::SEL_BIT];

  // Only the select bit takes writes; the weight field ignores them
  always_comb
  begin
    sel_next = sel_reg;
    if (reg_wr_en && addr_hit)
      sel_next[addr_idx] = wdata_sel;
  end

  // Read data: select bit on top, fixed weight below, zero when unmapped
  always_comb
  begin
    rdata_next = rdata_reg;
    rd_valid_next = reg_rd_en;
    if (reg_rd_en)
    begin
      if (addr_hit)
      begin
        rdata_next = {sel_reg[addr_idx],
          egress_sched_pkg::weight_of(~addr_idx[1:0])};
      end
      else
        rdata_next = egress_sched_pkg::READ_UNMAPPED;
    end
  end

  // Register state
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_reg <= {egress_sched_pkg::NUM_SCHED_REGS{egress_sched_pkg::SEL_RESET}};
      rdata_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
    end
    else
    begin
      sel_reg <= sel_next;
      rdata_reg <= rdata_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rd_valid = rd_valid_reg;

  // Select bits by queue number; index 0 of each port holds queue 3
  assign p2_sel_bits = {sel_reg[0], sel_reg[1], sel_reg[2], sel_reg[3]};
  assign p3_sel_bits = {sel_reg[4], sel_reg[5], sel_reg[6], sel_reg[7]};

  // Port 2 selector
  egress_port_sched #(
    .CREDIT_W(CREDIT_W)
  ) u_port2 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sel_bits(p2_sel_bits),
    .strict_global(strict_global),
    .two_queue(p2_two_queue),
    .queue_pending(p2_queue_pending),
    .frame_done(p2_frame_done),
    .queue_sel_reg(p2_queue_sel),
    .sel_valid_reg(p2_sel_valid),
    .weighted_reg(p2_weighted)
  );

  // Port 3 selector
  egress_port_sched #(
    .CREDIT_W(CREDIT_W)
  ) u_port3 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sel_bits(p3_sel_bits),
    .strict_global(strict_global),
    .two_queue(p3_two_queue),
    .queue_pending(p3_queue_pending),
    .frame_done(p3_frame_done),
    .queue_sel_reg(p3_queue_sel),
    .sel_valid_reg(p3_sel_valid),
    .weighted_reg(p3_weighted)
  );

  property p_sel_write;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_wr_en && reg_addr == egress_sched_pkg::OFS_P2_Q1)
      |=> (sel_reg[2] == $past(wdata_sel));
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("select bit write not stored");

  property p_sel_readback;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_wr_en && reg_addr == egress_sched_pkg::OFS_P2_Q3 && !reg_rd_en)
      ##1 (reg_rd_en && reg_addr == egress_sched_pkg::OFS_P2_Q3 && !reg_wr_en)
      |=> (reg_rd_valid && reg_rdata[7] == $past(wdata_sel, 2));
  endproperty
  a_sel_readback: assert property (p_sel_readback)
    else $error("select bit read back wrong");

  property p_weight_q3;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_rd_en && reg_addr == egress_sched_pkg::OFS_P3_Q3)
      |=> (reg_rdata[6:0] == egress_sched_pkg::WEIGHT_Q3);
  endproperty
  a_weight_q3: assert property (p_weight_q3)
    else $error("queue 3 weight field not 8");

  property p_weight_q0;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_rd_en && reg_addr == egress_sched_pkg::OFS_P2_Q0)
      |=> (reg_rdata[6:0] == egress_sched_pkg::WEIGHT_Q0);
  endproperty
  a_weight_q0: assert property (p_weight_q0)
    else $error("queue 0 weight field not 1");

  property p_unmapped;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_rd_en && reg_addr == 8'hbb) |=> (reg_rdata == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_p3_q0_clears;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_wr_en && reg_addr == egress_sched_pkg::OFS_P3_Q0 && !wdata_sel)
      |=> ##1 !p3_weighted || strict_global || p3_sel_bits != 4'h0;
  endproperty
  a_p3_q0_clears: assert property (p_p3_q0_clears)
    else $error("port 3 queue 0 select ignored");

  property p_strict_mode;
    @(posedge sys_clk) disable iff (!rst_n)
    (p2_sel_bits == 4'h0 && !strict_global) |=> !p2_weighted;
  endproperty
  a_strict_mode: assert property (p_strict_mode)
    else $error("port 2 not strict with all selects clear");

endmodule
`default_nettype wire

/* hw/egress_sched_pkg.sv */
// Constants and types shared by the egress queue scheduling register bank
package egress_sched_pkg;

  // Register offsets on the management register port
  localparam logic [7:0] OFS_P2_Q3 = 8'hb3;
  localparam logic [7:0] OFS_P2_Q2 = 8'hb4;
  localparam logic [7:0] OFS_P2_Q1 = 8'hb5;
  localparam logic [7:0] OFS_P2_Q0 = 8'hb6;
  localparam logic [7:0] OFS_P3_Q3 = 8'hb7;
  localparam logic [7:0] OFS_P3_Q2 = 8'hb8;
  localparam logic [7:0] OFS_P3_Q1 = 8'hb9;
  localparam logic [7:0] OFS_P3_Q0 = 8'hba;
  localparam logic [7:0] OFS_FIRST = OFS_P2_Q3;
  localparam logic [7:0] OFS_LAST = OFS_P3_Q0;
  localparam int NUM_SCHED_REGS = 8;

  // Field layout of each queue register
  localparam int SEL_BIT = 7;
  localparam logic SEL_RESET = 1'b1;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Fixed weights held in the read-only low field, by queue number
  localparam logic [6:0] WEIGHT_Q3 = 7'h08;
  localparam logic [6:0] WEIGHT_Q2 = 7'h04;
  localparam logic [6:0] WEIGHT_Q1 = 7'h02;
  localparam logic [6:0] WEIGHT_Q0 = 7'h01;

  // Weights used when a port runs two queues (queue 1 high, queue 0 low)
  localparam logic [6:0] WEIGHT2_HI = 7'h02;
  localparam logic [6:0] WEIGHT2_LO = 7'h01;
  localparam logic [3:0] LANES_FOUR = 4'hf;
  localparam logic [3:0] LANES_TWO = 4'h3;

  // Scheduling discipline of one port
  typedef enum logic [1:0] {
    MODE_STRICT = 2'b01,
    MODE_WEIGHTED = 2'b10
  } mode_t;

  // Read-only weight field for a queue number
  function automatic logic [6:0] weight_of(input logic [1:0] queue);
    logic [6:0] w;
    case (queue)
      2'h3: w = WEIGHT_Q3;
      2'h2: w = WEIGHT_Q2;
      2'h1: w = WEIGHT_Q1;
      default: w = WEIGHT_Q0;
    endcase
    return w;
  endfunction

endpackage

/* verif/egress_queue_sched_select_test.sv */
// Self-checking testbench for the egress queue scheduling register bank
`timescale 1ns/1ps
`default_nettype none

module egress_queue_sched_select_test;
  // Design inputs, all given a value at time zero
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd_en = 1'b0;
  logic strict_global = 1'b0;
  logic p2_two_queue = 1'b0;
  logic p3_two_queue = 1'b0;
  logic [3:0] p2_queue_pending = 4'h0;
  logic [3:0] p3_queue_pending = 4'h0;
  logic p2_frame_done = 1'b0;
  logic p3_frame_done = 1'b0;
  // Design outputs
  logic [7:0] reg_rdata;
  logic reg_rd_valid;
  logic [1:0] p2_queue_sel;
  logic p2_sel_valid;
  logic p2_weighted;
  logic [1:0] p3_queue_sel;
  logic p3_sel_valid;
  logic p3_weighted;
  // Bookkeeping
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int cnt[4];
  logic [6:0] wt[4] = '{7'h01, 7'h02, 7'h04, 7'h08};

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  egress_queue_sched_select #(.CREDIT_W(4)) i_egress_queue_sched_select (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .strict_global(strict_global), .p2_two_queue(p2_two_queue),
    .p3_two_queue(p3_two_queue),
    .p2_queue_pending(p2_queue_pending), .p2_frame_done(p2_frame_done),
    .p2_queue_sel(p2_queue_sel), .p2_sel_valid(p2_sel_valid), .p2_weighted(p2_weighted),
    .p3_queue_pending(p3_queue_pending), .p3_frame_done(p3_frame_done),
    .p3_queue_sel(p3_queue_sel), .p3_sel_valid(p3_sel_valid), .p3_weighted(p3_weighted)
  );

  // Cuts a hang short well past the expected run length
  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      err_count++;
      $display("[ERR] %0t timeout", $time);
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Step to just after the next rising edge
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Write strobe one cycle, then an idle cycle so back-to-back strobes stay apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    tick();
    reg_wr_en = 1'b0;
    tick();
  endtask

  // Write, then read the same offset on the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    tick();
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b1;
    tick();
    reg_rd_en = 1'b0;
    check({7'h00, reg_rd_valid}, 8'h01, "wr-rd valid");
    check(reg_rdata, exp, "wr-rd data");
    tick();
  endtask

  // Read strobe one cycle; data and valid land one cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd_en = 1'b1;
    tick();
    reg_rd_en = 1'b0;
    check({7'h00, reg_rd_valid}, 8'h01, "read valid");
    check(reg_rdata, exp, "read data");
    tick();
  endtask

  // Serve n frames on one port and count the queues picked
  task automatic frames(input logic p3, input int n);
    cnt = '{0, 0, 0, 0};
    repeat (n)
    begin
      tick();
      tick();
      if (p3)
      begin
        check({7'h00, p3_sel_valid}, 8'h01, "p3 valid");
        cnt[p3_queue_sel]++;
        p3_frame_done = 1'b1;
      end
      else
      begin
        check({7'h00, p2_sel_valid}, 8'h01, "p2 valid");
        cnt[p2_queue_sel]++;
        p2_frame_done = 1'b1;
      end
      tick();
      p2_frame_done = 1'b0;
      p3_frame_done = 1'b0;
    end
  endtask

  // Reset values of every queue register, and unmapped places
  task automatic test_reset;
    for (int k = 0; k < 4; k++)
    begin
      rd(8'hb6 - 8'(k), {1'b1, wt[k]});
      rd(8'hba - 8'(k), {1'b1, wt[k]});
    end
    wr(8'hbb, 8'hff);
    rd(8'hbb, 8'h00);
    rd(8'hb2, 8'h00);
    $display("test reset done");
  endtask

  // Only the select bit takes a write; low field stays fixed
  task automatic test_rw;
    for (int k = 0; k < 8; k++)
      wr(8'hb3 + 8'(k), 8'h7f);
    for (int k = 0; k < 4; k++)
    begin
      rd(8'hb6 - 8'(k), {1'b0, wt[k]});
      rd(8'hba - 8'(k), {1'b0, wt[k]});
    end
    for (int k = 0; k < 8; k++)
      wr(8'hb3 + 8'(k), 8'h80);
    wr_rd(8'hb3, 8'h00, 8'h08);
    wr(8'hb3, 8'h80);
    rd(8'hb3, 8'h88);
    rd(8'hba, 8'h81);
    $display("test rw done");
  endtask

  // Four queues weighted 8:4:2:1 over one full round
  task automatic test_weighted4;
    p3_queue_pending = 4'hf;
    frames(1'b1, 15);
    check({7'h00, p3_weighted}, 8'h01, "p3 weighted");
    check(8'(cnt[3]), 8'h08, "q3 share");
    check(8'(cnt[2]), 8'h04, "q2 share");
    check(8'(cnt[1]), 8'h02, "q1 share");
    check(8'(cnt[0]), 8'h01, "q0 share");
    p3_queue_pending = 4'h0;
    $display("test weighted four done");
  endtask

  // Two queues weighted 2:1 over two rounds
  task automatic test_weighted2;
    p2_two_queue = 1'b1;
    p2_queue_pending = 4'h3;
    frames(1'b0, 6);
    check({7'h00, p2_weighted}, 8'h01, "p2 weighted");
    check(8'(cnt[1]), 8'h04, "high share");
    check(8'(cnt[0]), 8'h02, "low share");
    p2_queue_pending = 4'he;
    tick();
    tick();
    check({7'h00, p2_sel_valid}, 8'h01, "two-queue valid");
    check({6'h00, p2_queue_sel}, 8'h01, "two-queue masks upper");
    p2_queue_pending = 4'h0;
    p2_two_queue = 1'b0;
    $display("test weighted two done");
  endtask

  // Strict order needs all four selects and the global bit clear
  task automatic test_strict;
    for (int k = 0; k < 4; k++)
      wr(8'hb7 + 8'(k), 8'h00);
    p3_queue_pending = 4'hf;
    tick();
    tick();
    check({6'h00, p3_queue_sel}, 8'h03, "strict top pick");
    p3_queue_pending = 4'h6;
    tick();
    tick();
    check({7'h00, p3_weighted}, 8'h00, "strict mode");
    check({6'h00, p3_queue_sel}, 8'h02, "strict high pick");
    p3_queue_pending = 4'h1;
    tick();
    tick();
    check({6'h00, p3_queue_sel}, 8'h00, "strict low pick");
    strict_global = 1'b1;
    tick();
    tick();
    check({7'h00, p3_weighted}, 8'h01, "global bit set");
    strict_global = 1'b0;
    tick();
    tick();
    check({7'h00, p3_weighted}, 8'h00, "global bit clear");
    wr(8'hba, 8'h80);
    tick();
    tick();
    check({7'h00, p3_weighted}, 8'h01, "queue 0 select set");
    p3_queue_pending = 4'h0;
    $display("test strict done");
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    test_reset();
    test_rw();
    test_weighted4();
    test_weighted2();
    test_strict();
    summarize();
  end
endmodule

`default_nettype wire
